/* include/bsw_map.vh */
`ifndef BSW_MAP_VH
`define BSW_MAP_VH
// Command codes served here
`define BSW_CMD_STATUS        8'h16
`define BSW_CMD_CYCLES        8'h17
`define BSW_CMD_CAPACITY      8'h18
`define BSW_CMD_VOLTAGE       8'h19
// Standard codes that this device leaves out
`define BSW_CMD_UNSUP_LO      8'h1d
`define BSW_CMD_UNSUP_HI      8'h1f
// Codes handled by neighbouring blocks
`define BSW_CMD_STD_HI        8'h1c
`define BSW_CMD_BLK_LO        8'h20
`define BSW_CMD_BLK_HI        8'h23
`define BSW_CMD_PACK          8'h2f
// Status word bit positions
`define BSW_B_OVER_CHG        15
`define BSW_B_TERM_CHG        14
`define BSW_B_RSVD_HI         13
`define BSW_B_OVER_TEMP       12
`define BSW_B_TERM_DSG        11
`define BSW_B_RSVD_LO         10
`define BSW_B_CAP_ALARM       9
`define BSW_B_TIME_ALARM      8
`define BSW_B_INIT            7
`define BSW_B_DSG             6
`define BSW_B_FULL            5
`define BSW_B_EMPTY           4
`define BSW_ERR_MSB           2
// Error codes
`define BSW_ERR_OK            3'h0
`define BSW_ERR_BUSY          3'h1
`define BSW_ERR_RSVD          3'h2
`define BSW_ERR_UNSUP         3'h3
`define BSW_ERR_DENIED        3'h4
`define BSW_ERR_OVF           3'h5
`define BSW_ERR_SIZE          3'h6
`define BSW_ERR_UNKNOWN       3'h7
// Reset values and limits
`define BSW_STATUS_RST        16'h0000
`define BSW_CYCLE_MAX         16'hffff
`define BSW_FULL_CLR_PCT      8'h14
`define BSW_FILTER_MULT       8'h0a
`define BSW_DSG_PRODUCT       24'h0057e4
// Timing: one second of core_clk at 8 ns
`define BSW_SEC_NS            1000000000
`define BSW_CLK_NS            8
`endif

/* rtl/bsw_sync.v */
`timescale 1ns/1ns
`default_nettype none
module bsw_sync #(
  parameter W = 1
) (
  input  wire         core_clk,
  input  wire         resetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_q;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge core_clk) begin
        if (!resetn) begin
          meta_q[i] <= 1'b0;
          q[i]      <= 1'b0;
        end else begin
          meta_q[i] <= d[i];
          q[i]      <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule // bsw_sync
`default_nettype wire

/* rtl/bsw_status.v */
`timescale 1ns/1ns
`default_nettype none
`include "bsw_map.vh"
module bsw_status #(
  parameter SEC_CYCLES = `BSW_SEC_NS / `BSW_CLK_NS
) (
  input  wire        core_clk,
  input  wire        resetn,
  // Measurement front end, its own clock domain
  input  wire        meas_clk,
  input  wire        charge_act,
  input  wire        discharge_act,
  input  wire        overcharge_hit,
  input  wire        chg_param_oor,
  input  wire        chg_term,
  input  wire        cell_undervoltage_flag,
  input  wire [15:0] temperature,
  input  wire [15:0] pack_voltage,
  input  wire [15:0] single_cell_voltage,
  input  wire [15:0] current_mag,
  input  wire [15:0] remaining_charge_count,
  input  wire [15:0] remaining_cap,
  input  wire [15:0] avg_time_to_empty,
  input  wire [7:0]  rel_charge_pct,
  // Configuration loader, same clock
  input  wire        ee_load_done,
  input  wire        ee_load_ok,
  input  wire        ee_busy,
  input  wire [7:0]  filter_val,
  input  wire [15:0] max_temperature_limit,
  input  wire [15:0] final_discharge_threshold,
  input  wire [15:0] warn_discharge_threshold,
  input  wire [15:0] overload_current,
  input  wire [7:0]  battery_low_pct,
  input  wire [7:0]  full_clear_pct,
  input  wire [15:0] cycle_init,
  input  wire [15:0] design_cap_mah,
  input  wire [15:0] design_cap_10mwh,
  input  wire [15:0] design_voltage,
  input  wire        cycle_inc,
  // Host settings and command strobe, same clock
  input  wire        cap_mode,
  input  wire [15:0] cap_alarm_level,
  input  wire [15:0] time_alarm_level,
  input  wire        cmd_valid,
  input  wire [7:0]  cmd_code,
  input  wire        cmd_write,
  input  wire        cmd_size_ok,
  input  wire        cmd_ovf,
  input  wire        cmd_fault,
  input  wire        alarm_req,
  output reg         rsp_valid_q,
  output reg         rsp_hit_q,
  output reg  [15:0] rsp_data_q,
  output reg  [2:0]  rsp_err_q,
  output reg  [15:0] status_q,
  output reg         bcast_valid_q,
  output reg  [15:0] bcast_data_q,
  output reg         ee_cycle_wr_q,
  output reg  [15:0] ee_cycle_data_q
);
  localparam SYNC_W = 7 + 16 * 7 + 8;
  wire [SYNC_W-1:0] raw_in;
  wire [SYNC_W-1:0] syn;
  // Multi-bit values are read a few cycles after a meas_clk rise, so the
  // front end must hold them steady across that edge.
  assign raw_in = {meas_clk, charge_act, discharge_act, overcharge_hit,
                   chg_param_oor, chg_term, cell_undervoltage_flag,
                   temperature, pack_voltage, single_cell_voltage,
                   current_mag, remaining_charge_count, remaining_cap,
                   avg_time_to_empty, rel_charge_pct};

  bsw_sync #(.W(SYNC_W)) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .d        (raw_in),
    .q        (syn)
  );

  wire        m_clk  = syn[SYNC_W-1];
  wire        s_chg  = syn[SYNC_W-2];
  wire        s_dsg  = syn[SYNC_W-3];
  wire        s_ovc  = syn[SYNC_W-4];
  wire        s_oor  = syn[SYNC_W-5];
  wire        s_term = syn[SYNC_W-6];
  wire        s_cuv  = syn[SYNC_W-7];
  wire [15:0] s_temp = syn[119:104];
  wire [15:0] s_pv   = syn[103:88];
  wire [15:0] s_cv   = syn[87:72];
  wire [15:0] s_cur  = syn[71:56];
  wire [15:0] s_rm   = syn[55:40];
  wire [15:0] s_rc   = syn[39:24];
  wire [15:0] s_tte  = syn[23:8];
  wire [7:0]  s_pct  = syn[7:0];

  // Decoded command class, reused for answers and error codes
  localparam [1:0] CLS_SERVED = 2'h0;
  localparam [1:0] CLS_OTHER  = 2'h1;
  localparam [1:0] CLS_UNSUP  = 2'h2;
  localparam [1:0] CLS_RSVD   = 2'h3;

  function [1:0] cmd_class;
    input [7:0] c;
    begin
      if (c >= `BSW_CMD_STATUS && c <= `BSW_CMD_VOLTAGE)
        cmd_class = CLS_SERVED;
      else if (c >= `BSW_CMD_UNSUP_LO && c <= `BSW_CMD_UNSUP_HI)
        cmd_class = CLS_UNSUP;
      else if (c <= `BSW_CMD_STD_HI || c == `BSW_CMD_PACK ||
               (c >= `BSW_CMD_BLK_LO && c <= `BSW_CMD_BLK_HI))
        cmd_class = CLS_OTHER;
      else
        cmd_class = CLS_RSVD;
    end
  endfunction

  // Command phases, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ANS  = 2'b10;

  reg  [1:0]  state_q;
  reg         m_clk_d_q;
  reg  [26:0] pre_q;
  reg  [15:0] idle_s_q;
  reg  [15:0] nochg_s_q;
  reg  [15:0] rc_prev_q;
  reg  [15:0] tte_prev_q;
  reg  [15:0] cycle_q;
  reg  [2:0]  err_q;
  reg  [7:0]  flag_q;
  reg  [3:0]  sflag_q;
  reg  [7:0]  cmd_q;
  reg  [2:0]  cmd_err_q;

  wire        meas_upd = m_clk & ~m_clk_d_q;
  wire        sec_tick = ({5'h00, pre_q} == SEC_CYCLES - 1);
  wire [15:0] filt_lim = {8'h00, filter_val} * {8'h00, `BSW_FILTER_MULT};
  wire [23:0] dsg_prod = {8'h00, nochg_s_q} * {16'h0000, filter_val};
  wire        idle_out = (filter_val != 8'h00) &&
                         (idle_s_q >= filt_lim);
  wire        nochg_out = (filter_val != 8'h00) &&
                          (dsg_prod >= `BSW_DSG_PRODUCT);
  wire        dsg_now = s_dsg | nochg_out;

  // Status word with reserved bits forced low
  wire [15:0] word = {flag_q[7:6], 1'b0, flag_q[4:3], 1'b0, flag_q[1:0],
                      sflag_q, 1'b0, err_q};

  // Seconds base and activity timers
  always @(posedge core_clk) begin
    if (!resetn) begin
      m_clk_d_q <= 1'b0;
      pre_q     <= 27'h0000000;
      idle_s_q  <= 16'h0000;
      nochg_s_q <= 16'h0000;
    end else begin
      m_clk_d_q <= m_clk;
      pre_q     <= sec_tick ? 27'h0000000 : pre_q + 27'h0000001;
      if (s_chg | s_dsg)
        idle_s_q <= 16'h0000;
      else if (sec_tick && idle_s_q != 16'hffff)
        idle_s_q <= idle_s_q + 16'h0001;
      if (s_chg)
        nochg_s_q <= 16'h0000;
      else if (sec_tick && nochg_s_q != 16'hffff)
        nochg_s_q <= nochg_s_q + 16'h0001;
    end
  end

  // Alarm flags: [7]=15 ... [0]=8 by position, sets beat clears except [6], where discharging wins
  always @(posedge core_clk) begin
    if (!resetn) begin
      flag_q     <= 8'h00;
      rc_prev_q  <= 16'h0000;
      tte_prev_q <= 16'h0000;
    end else if (meas_upd) begin
      rc_prev_q  <= s_rc;
      tte_prev_q <= s_tte;
      if (s_ovc)
        flag_q[7] <= 1'b1;
      else if (s_dsg | idle_out)
        flag_q[7] <= 1'b0;
      flag_q[6] <= (s_oor | s_term) & ~dsg_now;
      flag_q[4] <= s_temp >= max_temperature_limit;
      flag_q[3] <= (s_rm == 16'h0000) ||
                   (s_pv <= final_discharge_threshold) || s_cuv;
      if (s_rc < cap_alarm_level)
        flag_q[1] <= 1'b1;
      else if (cap_alarm_level < s_rc || s_rc > rc_prev_q)
        flag_q[1] <= 1'b0;
      if (s_tte < time_alarm_level)
        flag_q[0] <= 1'b1;
      else if (time_alarm_level < s_tte || s_tte > tte_prev_q)
        flag_q[0] <= 1'b0;
    end
  end

  // State flags: [3]=init [2]=discharging [1]=full [0]=empty
  always @(posedge core_clk) begin
    if (!resetn) begin
      sflag_q <= 4'h0;
    end else begin
      if (ee_load_done)
        sflag_q[3] <= ee_load_ok;
      if (meas_upd) begin
        if (dsg_now)
          sflag_q[2] <= 1'b1;
        else if (s_chg)
          sflag_q[2] <= 1'b0;
        if (s_term | s_ovc)
          sflag_q[1] <= 1'b1;
        else if (s_pct <= full_clear_pct)
          sflag_q[1] <= 1'b0;
        if (((s_pv < warn_discharge_threshold) ||
             (s_cv < warn_discharge_threshold)) &&
            (s_cur < overload_current) || (s_pct < battery_low_pct))
          sflag_q[0] <= 1'b1;
        else if (s_pct >= `BSW_FULL_CLR_PCT)
          sflag_q[0] <= 1'b0;
      end
    end
  end

  // Cycle count with saturation and write-back request
  always @(posedge core_clk) begin
    if (!resetn) begin
      cycle_q         <= 16'h0000;
      ee_cycle_wr_q   <= 1'b0;
      ee_cycle_data_q <= 16'h0000;
    end else begin
      ee_cycle_wr_q <= 1'b0;
      if (ee_load_done && ee_load_ok) begin
        cycle_q <= cycle_init;
      end else if (cycle_inc && cycle_q != `BSW_CYCLE_MAX) begin
        cycle_q         <= cycle_q + 16'h0001;
        ee_cycle_wr_q   <= 1'b1;
        ee_cycle_data_q <= cycle_q + 16'h0001;
      end
    end
  end

  // Error for a newly taken command, in priority order
  reg [2:0] new_err;
  always @* begin
    new_err = `BSW_ERR_OK;
    if (ee_busy)
      new_err = `BSW_ERR_BUSY;
    else if (cmd_class(cmd_code) == CLS_RSVD)
      new_err = `BSW_ERR_RSVD;
    else if (cmd_class(cmd_code) == CLS_UNSUP)
      new_err = `BSW_ERR_UNSUP;
    else if (cmd_write && cmd_class(cmd_code) == CLS_SERVED)
      new_err = `BSW_ERR_DENIED;
    else if (cmd_write && !cmd_size_ok)
      new_err = `BSW_ERR_SIZE;
    else if (cmd_ovf)
      new_err = `BSW_ERR_OVF;
    else if (cmd_fault)
      new_err = `BSW_ERR_UNKNOWN;
  end

  // Command handling and answers
  always @(posedge core_clk) begin
    if (!resetn) begin
      state_q       <= ST_IDLE;
      cmd_q         <= 8'h00;
      cmd_err_q     <= `BSW_ERR_OK;
      err_q         <= `BSW_ERR_OK;
      rsp_valid_q   <= 1'b0;
      rsp_hit_q     <= 1'b0;
      rsp_data_q    <= 16'h0000;
      rsp_err_q     <= `BSW_ERR_OK;
      status_q      <= `BSW_STATUS_RST;
      bcast_valid_q <= 1'b0;
      bcast_data_q  <= 16'h0000;
    end else begin
      rsp_valid_q   <= 1'b0;
      bcast_valid_q <= 1'b0;
      status_q      <= word;
      if (alarm_req) begin
        bcast_valid_q <= 1'b1;
        bcast_data_q  <= {word[15:3], 3'h7};
      end
      case (state_q)
        ST_IDLE: begin
          if (cmd_valid) begin
            cmd_q     <= cmd_code;
            cmd_err_q <= new_err;
            state_q   <= ST_ANS;
          end
        end
        ST_ANS: begin
          // The status read reports the previous command's error first
          rsp_valid_q <= 1'b1;
          rsp_err_q   <= cmd_err_q;
          rsp_hit_q   <= (cmd_err_q == `BSW_ERR_OK) &&
                         (cmd_class(cmd_q) == CLS_SERVED);
          err_q       <= cmd_err_q;
          rsp_data_q  <= 16'h0000;
          if (cmd_err_q == `BSW_ERR_OK) begin
            case (cmd_q)
              `BSW_CMD_STATUS:   rsp_data_q <= word;
              `BSW_CMD_CYCLES:   rsp_data_q <= cycle_q;
              `BSW_CMD_CAPACITY: rsp_data_q <= cap_mode ?
                                   design_cap_10mwh :
                                   design_cap_mah;
              `BSW_CMD_VOLTAGE:  rsp_data_q <= design_voltage;
              default:           rsp_data_q <= 16'h0000;
            endcase
          end
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // bsw_status
`default_nettype wire

/* verification/bsw_status_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module bsw_status_assertions (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        ee_busy,
  input wire logic [15:0] design_voltage,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic        cmd_write,
  input wire logic        cmd_ovf,
  input wire logic        cmd_fault,
  input wire logic        alarm_req,
  input wire logic        rsp_valid_q,
  input wire logic        rsp_hit_q,
  input wire logic [15:0] rsp_data_q,
  input wire logic [2:0]  rsp_err_q,
  input wire logic [15:0] status_q,
  input wire logic        bcast_valid_q,
  input wire logic [15:0] bcast_data_q,
  input wire logic        ee_cycle_wr_q
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // A read of 0x19 that no higher-priority error can pre-empt
  wire volt_rd = cmd_valid && !ee_busy && !cmd_write && !cmd_ovf
                 && !cmd_fault && cmd_code == 8'h19;
  a_answer_time: assert property (
    cmd_valid && !$past(cmd_valid) |-> ##2 rsp_valid_q ##1 !rsp_valid_q)
    else $error("answer pulse not two cycles after command");
  a_busy_code: assert property (
    cmd_valid && ee_busy |-> ##2 rsp_err_q == 3'h1)
    else $error("busy command not answered with code 1");
  a_unsup_code: assert property (
    cmd_valid && !ee_busy && cmd_code inside {[8'h1d:8'h1f]}
    |-> ##2 rsp_err_q == 3'h3)
    else $error("unimplemented code not answered with code 3");
  a_denied_write: assert property (
    cmd_valid && !ee_busy && cmd_write && cmd_code inside {[8'h16:8'h19]}
    |-> ##2 rsp_err_q == 3'h4)
    else $error("read-only write not answered with code 4");
  a_volt_read: assert property (
    volt_rd |-> ##2 rsp_hit_q && rsp_data_q == design_voltage)
    else $error("voltage read returned wrong word");
  a_err_status: assert property (
    rsp_valid_q |-> ##[1:2] status_q[2:0] == rsp_err_q)
    else $error("status error field does not follow answer");
  a_bcast_err: assert property (
    alarm_req |=> bcast_valid_q && bcast_data_q[2:0] == 3'h7)
    else $error("broadcast missing or error bits not all high");
  a_rsvd_zero: assert property (
    !status_q[13] && !status_q[10] && !bcast_data_q[13] && !bcast_data_q[10])
    else $error("reserved status bit set");
  c_busy: cover property (rsp_valid_q && rsp_err_q == 3'h1);
  c_bcast: cover property (bcast_valid_q);
  c_wb: cover property (ee_cycle_wr_q);
endmodule // bsw_status_assertions
`default_nettype wire

/* verification/bsw_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module bsw_host_model (
  input  wire logic        core_clk,
  input  wire logic        rsp_valid_q,
  input  wire logic [2:0]  rsp_err_q,
  input  wire logic [15:0] rsp_data_q,
  output var  logic        cmd_valid,
  output var  logic [7:0]  cmd_code,
  output var  logic        cmd_write,
  output var  logic        cmd_size_ok,
  output var  logic        cmd_ovf,
  output var  logic        cmd_fault
);
  initial cmd_valid = 1'b0;
  initial {cmd_code, cmd_write, cmd_size_ok, cmd_ovf, cmd_fault} = 12'h000;
  // Qualifiers flip once the strobe drops, so a late sample cannot pass
  task automatic xfer(input logic [7:0] c, input logic w, s, o, f,
                      output logic [2:0] e, output logic [15:0] d);
    int n;
    cmd_valid = 1'b1;
    {cmd_code, cmd_write, cmd_size_ok, cmd_ovf, cmd_fault} = {c, w, s, o, f};
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    {cmd_code, cmd_write, cmd_size_ok, cmd_ovf, cmd_fault} = ~{c, w, s, o, f};
    n = 0;
    while (rsp_valid_q !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    e = (n < 4) ? rsp_err_q : 3'hx;
    d = rsp_data_q;
    @(posedge core_clk);
    #1;
  endtask
endmodule // bsw_host_model
`default_nettype wire

/* verification/bsw_status_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module bsw_status_tb;
  logic core_clk = 1'b0, resetn = 1'b0, meas_clk = 1'b0;
  logic charge_act = 1'b0, discharge_act = 1'b0, overcharge_hit = 1'b0;
  logic chg_param_oor = 1'b0, chg_term = 1'b0, cell_undervoltage_flag = 1'b0;
  logic ee_load_done = 1'b0, ee_load_ok = 1'b0, ee_busy = 1'b0;
  logic cycle_inc = 1'b0, cap_mode = 1'b0, alarm_req = 1'b0;
  logic [15:0] temperature = 16'h0064, pack_voltage = 16'h0fa0;
  logic [15:0] single_cell_voltage = 16'h0fa0, current_mag = 16'h0000;
  logic [15:0] remaining_charge_count = 16'h0064, remaining_cap = 16'h01f4;
  logic [15:0] avg_time_to_empty = 16'h01f4, max_temperature_limit = 16'h01f4;
  logic [15:0] overload_current = 16'h03e8, cap_alarm_level = 16'h0064;
  logic [15:0] final_discharge_threshold = 16'h0bb8, cycle_init = 16'hfffe;
  logic [15:0] warn_discharge_threshold = 16'h0ce4;
  logic [15:0] time_alarm_level = 16'h000a;
  logic [15:0] design_cap_mah, design_cap_10mwh, design_voltage, rd, ef;
  logic [7:0]  rel_charge_pct = 8'h32, battery_low_pct = 8'h0a;
  logic [7:0]  full_clear_pct = 8'h28, filter_val = 8'h00;
  wire         cmd_valid, cmd_write, cmd_size_ok, cmd_ovf, cmd_fault;
  wire         rsp_valid_q, rsp_hit_q, bcast_valid_q, ee_cycle_wr_q;
  wire [7:0]   cmd_code;
  wire [2:0]   rsp_err_q;
  wire [15:0]  rsp_data_q, status_q, bcast_data_q, ee_cycle_data_q;
  int          n_errors = 0, cmp_count = 0, seed = 16463, i;
  // Short second so the filter timers stay cheap in simulation
  bsw_status #(.SEC_CYCLES(10)) i_bsw_status (.*);
  bsw_host_model i_bsw_host_model (.*);
  always #4 core_clk = ~core_clk;
  // Code in bits 7..0, write flag in bit 8
  function automatic logic [2:0] exp_err(input logic [15:0] r);
    if (r[7:0] >= 8'h1d && r[7:0] <= 8'h1f) return 3'h3;
    if (r[8] && r[7:0] >= 8'h16 && r[7:0] <= 8'h19) return 3'h4;
    if (r[7:0] <= 8'h23 || r[7:0] == 8'h2f) return 3'h0;
    return 3'h2;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk3(input logic [2:0] g, e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t code %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic w, s, o, f,
                     input logic [2:0] x);
    logic [2:0] e;
    i_bsw_host_model.xfer(c, w, s, o, f, e, rd);
    chk3(e, x);
  endtask
  // One meas_clk period; the measurement clock stands still outside it
  task automatic ms(input logic [15:0] e);
    step(4);
    meas_clk = 1'b1;
    #32;
    meas_clk = 1'b0;
    #32;
    step(4);
    ef = e;
    chk(status_q & 16'hfff8, e);
  endtask
  task automatic end_sim;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    end_sim;
  end
  initial begin
    design_voltage = 16'($random(seed));
    design_cap_mah = 16'($random(seed));
    design_cap_10mwh = 16'($random(seed));
    step(16);
    resetn = 1'b1;
    ee_load_ok = 1'b1;
    ee_load_done = 1'b1;
    step(1);
    ee_load_done = 1'b0;
    ms(16'h0080);
    max_temperature_limit = 16'h0064;
    ms(16'h1080);
    temperature = 16'h0063;
    ms(16'h0080);
    remaining_charge_count = 16'h0000;
    ms(16'h0880);
    remaining_charge_count = 16'h0001;
    cell_undervoltage_flag = 1'b1;
    ms(16'h0880);
    cell_undervoltage_flag = 1'b0;
    pack_voltage = 16'h0bb8;
    ms(16'h0890);
    final_discharge_threshold = 16'h0bb7;
    ms(16'h0090);
    pack_voltage = 16'h0fa0;
    single_cell_voltage = 16'h0ce3;
    ms(16'h0090);
    current_mag = 16'h03e8;
    ms(16'h0080);
    rel_charge_pct = 8'h09;
    ms(16'h0090);
    rel_charge_pct = 8'h13;
    ms(16'h0090);
    rel_charge_pct = 8'h14;
    ms(16'h0080);
    rel_charge_pct = 8'h32;
    cap_alarm_level = 16'h01f5;
    ms(16'h0280);
    remaining_cap = 16'h01f6;
    ms(16'h0080);
    avg_time_to_empty = 16'h0009;
    ms(16'h0180);
    avg_time_to_empty = 16'h000a;
    ms(16'h0080);
    discharge_act = 1'b1;
    ms(16'h00c0);
    discharge_act = 1'b0;
    charge_act = 1'b1;
    ms(16'h0080);
    overcharge_hit = 1'b1;
    ms(16'h80a0);
    chg_param_oor = 1'b1;
    ms(16'hc0a0);
    chg_param_oor = 1'b0;
    ms(16'h80a0);
    overcharge_hit = 1'b0;
    charge_act = 1'b0;
    discharge_act = 1'b1;
    ms(16'h00e0);
    full_clear_pct = 8'h32;
    ms(16'h00c0);
    // Idle after overcharge clears the alarm only once the timeout expires
    discharge_act = 1'b0;
    overcharge_hit = 1'b1;
    charge_act = 1'b1;
    ms(16'h80a0);
    overcharge_hit = 1'b0;
    charge_act = 1'b0;
    filter_val = 8'h01;
    ms(16'h8080);
    step(100);
    ms(16'h0080);
    // No charge for long enough marks the pack as discharging
    filter_val = 8'hff;
    ms(16'h0080);
    step(760);
    ms(16'h00c0);
    alarm_req = 1'b1;
    step(1);
    alarm_req = 1'b0;
    rd = ef | 16'h0007;
    chk({bcast_valid_q, bcast_data_q[14:0]}, {1'b1, rd[14:0]});
    for (i = 0; i < 40; i++) begin
      rd = 16'($random(seed)) & 16'hff3f;
      cmd(rd[7:0], rd[8], 1'b1, 1'b0, 1'b0, exp_err(rd));
    end
    ee_busy = 1'b1;
    cmd(8'h30, 1'b0, 1'b1, 1'b0, 1'b0, 3'h1);
    ee_busy = 1'b0;
    cmd(8'h16, 1'b1, 1'b0, 1'b0, 1'b0, 3'h4);
    cmd(8'h15, 1'b1, 1'b0, 1'b0, 1'b0, 3'h6);
    cmd(8'h10, 1'b0, 1'b1, 1'b1, 1'b0, 3'h5);
    cmd(8'h10, 1'b0, 1'b1, 1'b0, 1'b1, 3'h7);
    cmd(8'h16, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0);
    chk(rd, ef | 16'h0007);
    cmd(8'h19, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0);
    chk(rd, design_voltage);
    for (i = 0; i < 2; i++) begin
      cap_mode = i[0];
      cmd(8'h18, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0);
      chk(rd, i ? design_cap_10mwh : design_cap_mah);
    end
    // Second increment meets saturation: no write-back, count held
    for (i = 0; i < 2; i++) begin
      cycle_inc = 1'b1;
      step(1);
      cycle_inc = 1'b0;
      // The write-back strobe stands for one cycle only
      rd = i ? 16'h7fff : 16'hffff;
      chk({ee_cycle_wr_q, ee_cycle_data_q[14:0]}, rd);
      cmd(8'h17, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0);
      chk(rd, 16'hffff);
    end
    ee_load_ok = 1'b0;
    ee_load_done = 1'b1;
    step(1);
    ee_load_done = 1'b0;
    step(3);
    chk(status_q & 16'hfff8, ef & 16'hff78);
    end_sim;
  end
endmodule // bsw_status_tb
bind bsw_status bsw_status_assertions i_bsw_status_assertions (.*);
`default_nettype wire
